// ---- logic/scp_pkg.sv ----
// Notes on behaviour
// - each transfer is thirteen bits, least significant bit first
// - word bits 2..0 must equal 101 to address this device
// - word bits 4..3 select gain, power, aux dac or control register
// - word bits 5..12 are the data byte, bit 5 least significant
// - gain register low six bits are the amplifier gain code
// - power bit 4 high enters low power, all but receive adc off
// - power bit 3 high powers down gain amplifier and anti-alias filter
// - power bit 2 high powers down transmit filters
// - power bit 1 high powers down timing recovery dac
// - power bit 0 high powers down main transmit dac
// - aux dac register low seven bits are straight binary dac code
// - control bit 2 high enables analog loopback
// - control bit 1 high bypasses and powers down anti-alias filter
// - control bit 0 selects 138 kHz (0) or 1 MHz (1) transmit filter
// - data and frame sync sampled on each serial clock falling edge
// - after matching select, next ten bits give register and data
package scp_pkg;
   localparam int         WORD_BITS    = 13;
   localparam logic [3:0] LAST_BIT     = 4'hc;
   localparam logic [2:0] CHIP_SEL     = 3'h5;
   localparam int         CS_LSB       = 0;
   localparam int         SEL_LSB      = 3;
   localparam int         DATA_LSB     = 5;
   localparam logic [1:0] SEL_GAIN     = 2'h0;
   localparam logic [1:0] SEL_POWER    = 2'h1;
   localparam logic [1:0] SEL_AUX      = 2'h2;
   localparam logic [1:0] SEL_CTRL     = 2'h3;
   localparam logic [7:0] REG_RESET    = 8'h00;
   localparam int         GAIN_W       = 6;
   localparam int         AUX_W        = 7;
   localparam int         PWR_LOW_POWER = 4;
   localparam int         PWR_RX_AMP   = 3;
   localparam int         PWR_TX_FILT  = 2;
   localparam int         PWR_AUX_DAC  = 1;
   localparam int         PWR_MAIN_DAC = 0;
   localparam int         CTL_LOOPBACK = 2;
   localparam int         CTL_AAF_BYP  = 1;
   localparam int         CTL_TX_BAND  = 0;
   localparam int         CTL_FACT_HI  = 7;
   localparam int         CTL_FACT_LO  = 4;
   localparam real        SCLK_TYP_NS  = 151.0;
endpackage

// ---- logic/scp_serial_control_port_regs.sv ----
`timescale 1ns/1ns
module scp_serial_control_port_regs (
   input  wire logic                     clk,
   input  wire logic                     reset_n,
   input  wire logic                     ser_clk,
   input  wire logic                     ser_data_in,
   input  wire logic                     frame_sync_in,
   output logic [scp_pkg::GAIN_W-1:0]    gain_code,
   output logic                          low_power,
   output logic                          rx_amp_off,
   output logic                          tx_filt_off,
   output logic                          aux_dac_off,
   output logic                          main_dac_off,
   output logic [scp_pkg::AUX_W-1:0]     aux_dac_code,
   output logic                          loopback_en,
   output logic                          aaf_bypass,
   output logic                          tx_band_sel,
   output logic                          factory_ctl_hi,
   output logic                          factory_ctl_lo
);
   import scp_pkg::*;

   // ------------------------------------------------------------
   // link side: word assembly on serial clock falling edge
   // ------------------------------------------------------------
   // no reset reaches this domain; every word opens with a frame
   // sync, which brings the shifter to a known state
   logic [WORD_BITS-2:0] shift_r;
   logic [WORD_BITS-2:0] shift_nxt;
   logic [3:0]           cnt_r;
   logic [3:0]           cnt_nxt;
   logic                 busy_r;
   logic                 busy_nxt;
   logic [9:0]           hold_r;
   logic [9:0]           hold_nxt;
   logic                 ready_r;
   logic                 ready_nxt;
   logic                 last_bit;
   logic                 addr_hit;

   always_comb begin
      shift_nxt = shift_r;
      cnt_nxt   = cnt_r;
      busy_nxt  = busy_r;
      hold_nxt  = hold_r;
      ready_nxt = ready_r;
      last_bit  = busy_r && (cnt_r == LAST_BIT);
      addr_hit  = (shift_r[CS_LSB +: 3] == CHIP_SEL);
      if (frame_sync_in) begin
         // frame sync marks bit 0 and restarts any word
         shift_nxt = {ser_data_in, shift_r[WORD_BITS-2:1]};
         cnt_nxt   = 4'h1;
         busy_nxt  = 1'b1;
         ready_nxt = 1'b0;
      end else if (last_bit) begin
         // bits 0..11 in shift_r, bit 12 still on the pin
         busy_nxt = 1'b0;
         if (addr_hit) begin
            hold_nxt  = {ser_data_in, shift_r[WORD_BITS-2:SEL_LSB]};
            ready_nxt = 1'b1;
         end
      end else if (busy_r) begin
         cnt_nxt   = cnt_r + 4'h1;
         shift_nxt = {ser_data_in, shift_r[WORD_BITS-2:1]};
      end
   end

   always_ff @(negedge ser_clk) begin
      shift_r <= shift_nxt;
      cnt_r   <= cnt_nxt;
      busy_r  <= busy_nxt;
      hold_r  <= hold_nxt;
      ready_r <= ready_nxt;
   end

   // ------------------------------------------------------------
   // crossing into clk domain
   // ------------------------------------------------------------
   // only the ready level is synchronised; the word it qualifies
   // stays still on the link side for as long as ready is up
   logic       rdy_s1_r;
   logic       rdy_s1_nxt;
   logic       rdy_s2_r;
   logic       rdy_s2_nxt;
   logic       rdy_seen_r;
   logic       rdy_seen_nxt;
   logic [9:0] word_r;
   logic [9:0] word_nxt;
   logic       load;

   always_comb begin
      rdy_s1_nxt   = ready_r;
      rdy_s2_nxt   = rdy_s1_r;
      // tracks the synchroniser through reset too, so a word that
      // was already waiting is not applied a second time
      rdy_seen_nxt = rdy_s2_r;
      word_nxt     = hold_r;
      load         = rdy_s2_r & ~rdy_seen_r;
   end

   always_ff @(posedge clk) begin
      rdy_s1_r   <= rdy_s1_nxt;
      rdy_s2_r   <= rdy_s2_nxt;
      rdy_seen_r <= rdy_seen_nxt;
      word_r     <= word_nxt;
   end

   // ------------------------------------------------------------
   // register select decode
   // ------------------------------------------------------------
   // one write strobe per accepted word
   logic [1:0] sel;
   logic [7:0] wdata;
   logic       wr_gain;
   logic       wr_pwr;
   logic       wr_aux;
   logic       wr_ctl;

   always_comb begin
      sel     = word_r[1:0];
      wdata   = word_r[9:2];
      wr_gain = 1'b0;
      wr_pwr  = 1'b0;
      wr_aux  = 1'b0;
      wr_ctl  = 1'b0;
      if (load) begin
         case (sel)
            SEL_GAIN:  wr_gain = 1'b1;
            SEL_POWER: wr_pwr  = 1'b1;
            SEL_AUX:   wr_aux  = 1'b1;
            SEL_CTRL:  wr_ctl  = 1'b1;
            default:   wr_gain = 1'b0;
         endcase
      end
   end

   // ------------------------------------------------------------
   // gain register
   // ------------------------------------------------------------
   logic [7:0]        gain_r;
   logic [7:0]        gain_nxt;
   logic [GAIN_W-1:0] gain_code_nxt;

   always_comb begin
      gain_nxt = gain_r;
      if (wr_gain) begin
         gain_nxt = wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         gain_r <= REG_RESET;
      end else begin
         gain_r <= gain_nxt;
      end
   end

   always_comb begin
      gain_code_nxt = gain_r[GAIN_W-1:0];
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         gain_code <= REG_RESET[GAIN_W-1:0];
      end else begin
         gain_code <= gain_code_nxt;
      end
   end

   // ------------------------------------------------------------
   // power register
   // ------------------------------------------------------------
   // low power mode forces every separate power-down on as well
   logic [7:0] pwr_r;
   logic [7:0] pwr_nxt;
   logic       lp_force;
   logic       low_power_nxt;
   logic       rx_amp_off_nxt;
   logic       tx_filt_off_nxt;
   logic       aux_dac_off_nxt;
   logic       main_dac_off_nxt;

   always_comb begin
      pwr_nxt = pwr_r;
      if (wr_pwr) begin
         pwr_nxt = wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         pwr_r <= REG_RESET;
      end else begin
         pwr_r <= pwr_nxt;
      end
   end

   always_comb begin
      lp_force         = pwr_r[PWR_LOW_POWER];
      low_power_nxt    = lp_force;
      rx_amp_off_nxt   = pwr_r[PWR_RX_AMP] | lp_force;
      tx_filt_off_nxt  = pwr_r[PWR_TX_FILT] | lp_force;
      aux_dac_off_nxt  = pwr_r[PWR_AUX_DAC] | lp_force;
      main_dac_off_nxt = pwr_r[PWR_MAIN_DAC] | lp_force;
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         low_power    <= REG_RESET[PWR_LOW_POWER];
         rx_amp_off   <= REG_RESET[PWR_RX_AMP];
         tx_filt_off  <= REG_RESET[PWR_TX_FILT];
         aux_dac_off  <= REG_RESET[PWR_AUX_DAC];
         main_dac_off <= REG_RESET[PWR_MAIN_DAC];
      end else begin
         low_power    <= low_power_nxt;
         rx_amp_off   <= rx_amp_off_nxt;
         tx_filt_off  <= tx_filt_off_nxt;
         aux_dac_off  <= aux_dac_off_nxt;
         main_dac_off <= main_dac_off_nxt;
      end
   end

   // ------------------------------------------------------------
   // auxiliary dac register
   // ------------------------------------------------------------
   logic [7:0]       aux_r;
   logic [7:0]       aux_nxt;
   logic [AUX_W-1:0] aux_dac_code_nxt;

   always_comb begin
      aux_nxt = aux_r;
      if (wr_aux) begin
         aux_nxt = wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         aux_r <= REG_RESET;
      end else begin
         aux_r <= aux_nxt;
      end
   end

   always_comb begin
      aux_dac_code_nxt = aux_r[AUX_W-1:0];
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         aux_dac_code <= REG_RESET[AUX_W-1:0];
      end else begin
         aux_dac_code <= aux_dac_code_nxt;
      end
   end

   // ------------------------------------------------------------
   // loopback and filter control register
   // ------------------------------------------------------------
   // bits 6, 5 and 3 are stored only
   logic [7:0] ctl_r;
   logic [7:0] ctl_nxt;
   logic       loopback_en_nxt;
   logic       aaf_bypass_nxt;
   logic       tx_band_sel_nxt;
   logic       factory_ctl_hi_nxt;
   logic       factory_ctl_lo_nxt;

   always_comb begin
      ctl_nxt = ctl_r;
      if (wr_ctl) begin
         ctl_nxt = wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ctl_r <= REG_RESET;
      end else begin
         ctl_r <= ctl_nxt;
      end
   end

   always_comb begin
      loopback_en_nxt    = ctl_r[CTL_LOOPBACK];
      aaf_bypass_nxt     = ctl_r[CTL_AAF_BYP];
      tx_band_sel_nxt    = ctl_r[CTL_TX_BAND];
      factory_ctl_hi_nxt = ctl_r[CTL_FACT_HI];
      factory_ctl_lo_nxt = ctl_r[CTL_FACT_LO];
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         loopback_en    <= REG_RESET[CTL_LOOPBACK];
         aaf_bypass     <= REG_RESET[CTL_AAF_BYP];
         tx_band_sel    <= REG_RESET[CTL_TX_BAND];
         factory_ctl_hi <= REG_RESET[CTL_FACT_HI];
         factory_ctl_lo <= REG_RESET[CTL_FACT_LO];
      end else begin
         loopback_en    <= loopback_en_nxt;
         aaf_bypass     <= aaf_bypass_nxt;
         tx_band_sel    <= tx_band_sel_nxt;
         factory_ctl_hi <= factory_ctl_hi_nxt;
         factory_ctl_lo <= factory_ctl_lo_nxt;
      end
   end

endmodule

// ---- dv/scp_checker.sv ----
`timescale 1ns/1ns
module scp_checker (
   input wire logic       clk,
   input wire logic       reset_n,
   input wire logic       ser_clk,
   input wire logic [5:0] gain_code,
   input wire logic [6:0] aux_dac_code,
   input wire logic       low_power,
   input wire logic       main_dac_off,
   input wire logic       tx_band_sel
);
   logic        sc_r;
   logic [3:0]  n_r, n_nxt;
   wire  [15:0] o = {gain_code, aux_dac_code, low_power, main_dac_off, tx_band_sel};
   always_comb n_nxt = !reset_n ? 4'hf : (sc_r && !ser_clk) ? 4'h0 : n_r + {3'h0, ~&n_r};
   always_ff @(posedge clk) {sc_r, n_r} <= {ser_clk, n_nxt};
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   a_lp_forces_off: assert property (low_power |-> main_dac_off) else $error("dac on");
   a_upd_late: assert property ($changed(o) |-> n_r inside {[2:4]}) else $error("early");
   a_idle_hold: assert property (n_r == 4'hf |-> $stable(o)) else $error("drift");
   a_one_update: assert property ($changed(o) |=> $stable(o)[*4]) else $error("twice");
   a_gain_only: assert property (
      $changed(gain_code) |-> $stable(o[9:0])) else $error("gain spill");
   a_aux_only: assert property (
      $changed(aux_dac_code) |-> $stable({gain_code, o[2:0]})) else $error("aux spill");
   a_pwr_only: assert property (
      $changed(o[2:1]) |-> $stable({o[15:3], o[0]})) else $error("power spill");
   a_ctl_only: assert property (
      $changed(tx_band_sel) |-> $stable(o[15:1])) else $error("ctl spill");
endmodule
bind scp_serial_control_port_regs scp_checker i_chk (.*);

// ---- dv/scp_host_model.sv ----
`timescale 1ns/1ns
module scp_host_model (
   output logic ser_clk,
   output logic ser_data_in,
   output logic frame_sync_in
);
   initial {ser_clk, ser_data_in, frame_sync_in} = 3'h4;
   // link clock idles high; released data shows inverted last bit
   task automatic send_word(input logic [12:0] w, input int nb);
      for (int i = 0; i < nb; i++) begin
         ser_data_in = w[i];
         frame_sync_in = (i == 0);
         #7 ser_clk = 1'b0;
         #8 ser_clk = 1'b1;
      end
      ser_data_in = ~ser_data_in;
      #100;
   endtask
endmodule

// ---- dv/testbench.sv ----
`timescale 1ns/1ns
module testbench;
   import scp_pkg::*;
   logic       clk, reset_n;
   wire  [5:0] gain_code;
   wire  [6:0] aux_dac_code;
   wire        ser_clk, ser_data_in, frame_sync_in, low_power, rx_amp_off, tx_filt_off;
   wire        aux_dac_off, main_dac_off, loopback_en, aaf_bypass, tx_band_sel;
   wire        factory_ctl_hi, factory_ctl_lo;
   logic [7:0] m [4] = '{default: 8'h00};
   int         error_cnt, total_checks, cyc;
   wire [22:0] obs = {gain_code, low_power, rx_amp_off, tx_filt_off, aux_dac_off,
      main_dac_off, aux_dac_code, loopback_en, aaf_bypass, tx_band_sel, factory_ctl_hi,
      factory_ctl_lo};
   scp_serial_control_port_regs i_dut (.*);
   scp_host_model i_host (.*);
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) if (cyc++ == 20000) report_and_stop(1'b1);
   task automatic report_and_stop(input bit late);
      error_cnt += late;
      if (error_cnt == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic wr(input logic [1:0] s, input logic [7:0] d,
      input logic [2:0] cs = CHIP_SEL, input int nb = WORD_BITS);
      i_host.send_word({d, s, cs}, nb);
      if (cs == CHIP_SEL && nb == WORD_BITS) m[s] = d;
      total_checks++;
      if (obs !== {m[0][5:0], m[1][4], m[1][3:0] | {4{m[1][4]}}, m[2][6:0], m[3][2:0],
         m[3][7], m[3][4]}) begin
         error_cnt++;
         $display("CHECK FAILED %0t obs %h", $time, obs);
      end
   endtask
   task automatic t_regs();
      for (int s = 0; s < 4; s++) wr(2'(s), 8'h00);
      for (int b = 0; b < 6; b++) wr(SEL_POWER, 8'h01 << b);
      wr(SEL_GAIN, 8'hd5);
      wr(SEL_AUX, 8'hb3);
      for (int b = 0; b < 8; b++) wr(SEL_CTRL, 8'h01 << b);
   endtask
   task automatic t_refuse();
      for (int c = 0; c < 7; c++) wr(SEL_AUX, 8'h3c, 3'(c + (c > 4)));
      wr(SEL_GAIN, 8'h2a, CHIP_SEL, 9);
      wr(SEL_GAIN, 8'h2a);
   endtask
   initial begin
      reset_n = 1'b0;
      repeat (16) @(posedge clk);
      #1 reset_n = 1'b1;
      t_regs();
      t_refuse();
      report_and_stop(1'b0);
   end
endmodule
